// *** spdc_dev_ctl_properties.sv ***
// checker: port-level properties of the control-two register block
`timescale 1ns/1ps
`default_nettype none
module spdc_dev_ctl_props (
    // clock and reset
    input wire logic                     i_clk,
    input wire logic                     i_rst_n,
    // register bus
    input wire logic                     i_hsel,
    input wire logic [11:0]              i_haddr,
    input wire logic [1:0]               i_htrans,
    input wire logic                     i_hwrite,
    input wire logic                     i_hready,
    input wire logic [31:0]              o_hrdata,
    input wire logic                     o_hreadyout,
    input wire logic                     o_hresp,
    // conversion check and state
    input wire spdc_pkg::spdc_conv_t     i_conv,
    input wire spdc_pkg::spdc_conv_rsp_t o_conv_rsp,
    input wire logic                     o_alt_routing_forward_enable,
    input wire logic                     o_alt_routing_forward_capable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // read of control two accepted at this edge
    wire logic rd_ctl = i_hsel && i_hready && i_htrans == spdc_pkg::HTRANS_NONSEQ
                        && !i_hwrite && i_haddr == spdc_pkg::OFS_DEV_CTL_TWO;
    wire logic en     = o_alt_routing_forward_enable;

    ready_high_a: assert property (o_hreadyout)
        else $error("hreadyout dropped");
    resp_okay_a: assert property (o_hresp == spdc_pkg::HRESP_OKAY)
        else $error("response not okay");
    conv_answer_a: assert property (i_conv.valid |=> o_conv_rsp.valid
        && o_conv_rsp.dev_num == $past(i_conv.dev_num)) else $error("no conversion answer");
    conv_idle_a: assert property (!i_conv.valid |=> !o_conv_rsp.valid)
        else $error("answer without request");
    conv_open_a: assert property (i_conv.valid && en |=>
        o_conv_rsp.allowed && !o_conv_rsp.forced) else $error("enabled check refused");
    conv_strict_a: assert property (i_conv.valid && !en |=> o_conv_rsp.forced
        && o_conv_rsp.allowed == ($past(i_conv.dev_num) == 5'h00)) else $error("zero rule lost");
    read_zero_a: assert property (rd_ctl |=> o_hrdata[31:6] == 26'h0
        && o_hrdata[4:0] == 5'h00) else $error("fixed bits not zero");
    enable_cap_a: assert property (en |-> o_alt_routing_forward_capable)
        else $error("enable without capability");
endmodule

bind spdc_port_dev_ctl spdc_dev_ctl_props u_spdc_dev_ctl_props (.i_clk, .i_rst_n, .i_hsel,
    .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_conv,
    .o_conv_rsp, .o_alt_routing_forward_enable, .o_alt_routing_forward_capable);
`default_nettype wire

// *** spdc_pkg.sv ***
// package: offsets, field layout, reset values and carriers for the control-two block
package spdc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 16;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_DEV_CAP_TWO = 12'h064;
    localparam logic [11:0] OFS_DEV_CTL_TWO = 12'h068;
    localparam logic [11:0] OFS_PORT_MODE   = 12'h080;
    localparam logic [11:0] OFS_CONV_STATUS = 12'h084;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_ALT_FWD      = 5;
    localparam int unsigned BIT_NO_RO_PASS   = 10;
    localparam int unsigned BIT_UPSTREAM     = 0;
    localparam int unsigned BIT_STAT_ALLOWED = 0;
    localparam int unsigned BIT_STAT_FORCED  = 1;
    localparam int unsigned STAT_DEV_LSB     = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_DEV_CTL_TWO = 16'h0000;
    localparam logic        RST_FWD_ENABLE  = 1'h0;
    localparam logic        RST_FWD_CAPABLE = 1'h1;
    localparam logic        RST_UPSTREAM    = 1'h0;
    localparam logic        RST_NO_RO_PASS  = 1'h1;

    // ------------------------------------------------------------
    // ahb encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // latched address phase of one transfer
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } spdc_aphase_t;

    // one type 1 to type 0 conversion check
    typedef struct packed {
        logic       valid;
        logic [4:0] dev_num;
    } spdc_conv_t;

    // answer of a conversion check
    typedef struct packed {
        logic       valid;
        logic       allowed;
        logic       forced;
        logic [4:0] dev_num;
    } spdc_conv_rsp_t;

endpackage

// *** spdc_port_dev_ctl.sv ***
// device control two register of a switch port, ahb-lite slave with conversion check
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - downstream forward enable bit5 rw, resets zero
// - enable set: device number not forced zero
// - capability clear: enable reads zero, ignores writes
// - upstream port: enable always reads zero
// - timeout value and disable bits read zero
// - atomic requester and egress bits read zero
// - ordering and latency enable bits read zero
// - reserved and prefix blocking bits read zero
// - capability rw downstream, reset one, keeps value
module spdc_port_dev_ctl #(
    parameter int unsigned ADDR_W = spdc_pkg::ADDR_W,
    parameter int unsigned DATA_W = spdc_pkg::DATA_W
) (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    // ahb-lite slave
    input  wire logic                i_hsel,
    input  wire logic [ADDR_W-1:0]   i_haddr,
    input  wire logic [1:0]          i_htrans,
    input  wire logic                i_hwrite,
    input  wire logic [2:0]          i_hsize,
    input  wire logic [DATA_W-1:0]   i_hwdata,
    input  wire logic                i_hready,
    output logic      [DATA_W-1:0]   o_hrdata,
    output logic                     o_hreadyout,
    output logic                     o_hresp,
    // conversion check request
    input  wire spdc_pkg::spdc_conv_t i_conv,
    // conversion check answer and port state
    output spdc_pkg::spdc_conv_rsp_t o_conv_rsp,
    output logic                     o_alt_routing_forward_enable,
    output logic                     o_alt_routing_forward_capable
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // forward enable as seen by software and by the conversion logic
    // one function keeps the read path and the conversion path in step
    function automatic logic eff_enable(
        input logic stored,
        input logic capable,
        input logic upstream
    );
        eff_enable = stored & capable & ~upstream;
    endfunction

    // capability as seen by software: zero on the upstream port
    function automatic logic eff_capable(
        input logic stored,
        input logic upstream
    );
        eff_capable = stored & ~upstream;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    spdc_pkg::spdc_aphase_t   aphase_ff;
    spdc_pkg::spdc_aphase_t   nxt_aphase;
    logic                     fwd_enable_ff;
    logic                     nxt_fwd_enable;
    logic                     fwd_capable_ff;
    logic                     nxt_fwd_capable;
    logic                     upstream_ff;
    logic                     nxt_upstream;
    logic [DATA_W-1:0]        hrdata_ff;
    logic [DATA_W-1:0]        nxt_hrdata;
    logic                     hreadyout_ff;
    logic                     nxt_hreadyout;
    spdc_pkg::spdc_conv_rsp_t conv_rsp_ff;
    spdc_pkg::spdc_conv_rsp_t nxt_conv_rsp;
    spdc_pkg::spdc_conv_rsp_t last_rsp_ff;
    spdc_pkg::spdc_conv_rsp_t nxt_last_rsp;
    logic                     enable_out_ff;
    logic                     capable_out_ff;
    logic                     nxt_enable_out;
    logic                     nxt_capable_out;

    // combinational helpers
    logic                     wr_hit;
    logic                     new_aphase;
    logic [15:0]              ctl_view;
    logic [31:0]              cap_view;
    logic                     view_enable;
    logic                     view_capable;

    // ------------------------------------------------------------
    // ahb address phase capture
    // ------------------------------------------------------------

    // hsize is not decoded: only whole-word transfers reach this slave
    // only nonseq is acted on; idle and busy leave the slave alone
    assign new_aphase = i_hsel & i_hready & (i_htrans == spdc_pkg::HTRANS_NONSEQ);

    // latch the address phase for the following data phase
    always_comb begin
        nxt_aphase = aphase_ff;
        if (i_hready) begin
            nxt_aphase.valid = new_aphase;
            nxt_aphase.write = i_hwrite;
            nxt_aphase.addr  = i_haddr;
        end
    end

    // a write lands during its data phase, when hwdata stands
    assign wr_hit = aphase_ff.valid & aphase_ff.write;

    // ------------------------------------------------------------
    // software writable state
    // ------------------------------------------------------------

    // next values of the stored bits; writes to read-only cases drop
    always_comb begin
        nxt_fwd_enable  = fwd_enable_ff;
        nxt_fwd_capable = fwd_capable_ff;
        nxt_upstream    = upstream_ff;
        if (wr_hit) begin
            unique case (aphase_ff.addr)
                spdc_pkg::OFS_DEV_CTL_TWO: begin
                    // only bit5 has storage; the other fields read as zero
                    if (!upstream_ff && fwd_capable_ff) begin
                        nxt_fwd_enable = i_hwdata[spdc_pkg::BIT_ALT_FWD];
                    end
                end
                spdc_pkg::OFS_DEV_CAP_TWO: begin
                    if (!upstream_ff) begin
                        nxt_fwd_capable = i_hwdata[spdc_pkg::BIT_ALT_FWD];
                    end
                end
                spdc_pkg::OFS_PORT_MODE: begin
                    // mode change keeps both stored bits untouched
                    nxt_upstream = i_hwdata[spdc_pkg::BIT_UPSTREAM];
                end
                default: begin
                    // unmapped or read-only: write ignored, still okay
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read views
    // ------------------------------------------------------------

    // hazard: a stale view would let a back-to-back read miss its write
    // views come from next values so a read right after a write sees it
    assign view_enable  = eff_enable(nxt_fwd_enable, nxt_fwd_capable, nxt_upstream);
    assign view_capable = eff_capable(nxt_fwd_capable, nxt_upstream);

    // control two: every bit but the forward enable is hard zero
    always_comb begin
        ctl_view                        = spdc_pkg::RST_DEV_CTL_TWO;
        ctl_view[spdc_pkg::BIT_ALT_FWD] = view_enable;
    end

    // capability two: forward capable plus the fixed ordering bit
    always_comb begin
        cap_view                           = '0;
        cap_view[spdc_pkg::BIT_ALT_FWD]    = view_capable;
        cap_view[spdc_pkg::BIT_NO_RO_PASS] = spdc_pkg::RST_NO_RO_PASS;
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------

    // read data is prepared one cycle early so the slave needs no wait
    always_comb begin
        nxt_hrdata = '0;
        if (new_aphase && !i_hwrite) begin
            unique case (i_haddr)
                spdc_pkg::OFS_DEV_CTL_TWO: begin
                    nxt_hrdata[15:0] = ctl_view;
                end
                spdc_pkg::OFS_DEV_CAP_TWO: begin
                    nxt_hrdata = cap_view;
                end
                spdc_pkg::OFS_PORT_MODE: begin
                    nxt_hrdata[spdc_pkg::BIT_UPSTREAM] = nxt_upstream;
                end
                spdc_pkg::OFS_CONV_STATUS: begin
                    nxt_hrdata[spdc_pkg::BIT_STAT_ALLOWED] = nxt_last_rsp.allowed;
                    nxt_hrdata[spdc_pkg::BIT_STAT_FORCED]  = nxt_last_rsp.forced;
                    nxt_hrdata[spdc_pkg::STAT_DEV_LSB +: 5] = nxt_last_rsp.dev_num;
                end
                default: begin
                    // unmapped addresses read as zero
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // type 1 to type 0 conversion check
    // ------------------------------------------------------------

    // dev_num is echoed so the requester can pair answers with requests
    // with forwarding on, any device number passes down; otherwise only zero
    always_comb begin
        nxt_conv_rsp         = '0;
        nxt_conv_rsp.valid   = i_conv.valid;
        nxt_conv_rsp.dev_num = i_conv.dev_num;
        if (eff_enable(fwd_enable_ff, fwd_capable_ff, upstream_ff)) begin
            nxt_conv_rsp.allowed = i_conv.valid;
            nxt_conv_rsp.forced  = 1'b0;
        end else begin
            nxt_conv_rsp.allowed = i_conv.valid & (i_conv.dev_num == 5'h00);
            nxt_conv_rsp.forced  = i_conv.valid;
        end
    end

    // last checked request kept for software to inspect
    always_comb begin
        nxt_last_rsp = last_rsp_ff;
        if (conv_rsp_ff.valid) begin
            nxt_last_rsp = conv_rsp_ff;
        end
    end

    // ------------------------------------------------------------
    // bus handshake and exported port state
    // ------------------------------------------------------------

    // zero wait states: every access finishes in its data phase
    always_comb begin
        nxt_hreadyout = 1'b1;
    end

    // exported bits built from next values so they match the stored state, except in reset and one cycle after, where capable reads zero
    always_comb begin
        nxt_enable_out  = view_enable;
        nxt_capable_out = view_capable;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // bus side flops; hreadyout stays high since every access is single cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            aphase_ff    <= '0;
            hrdata_ff    <= '0;
            hreadyout_ff <= 1'b1;
        end else begin
            aphase_ff    <= nxt_aphase;
            hrdata_ff    <= nxt_hrdata;
            hreadyout_ff <= nxt_hreadyout;
        end
    end

    // configuration bits; reset is the only thing that restores defaults
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fwd_enable_ff  <= spdc_pkg::RST_FWD_ENABLE;
            fwd_capable_ff <= spdc_pkg::RST_FWD_CAPABLE;
            upstream_ff    <= spdc_pkg::RST_UPSTREAM;
        end else begin
            fwd_enable_ff  <= nxt_fwd_enable;
            fwd_capable_ff <= nxt_fwd_capable;
            upstream_ff    <= nxt_upstream;
        end
    end

    // conversion answers and exported port state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            conv_rsp_ff    <= '0;
            last_rsp_ff    <= '0;
            enable_out_ff  <= 1'b0;
            capable_out_ff <= 1'b0;
        end else begin
            conv_rsp_ff    <= nxt_conv_rsp;
            last_rsp_ff    <= nxt_last_rsp;
            enable_out_ff  <= nxt_enable_out;
            capable_out_ff <= nxt_capable_out;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // all outputs but hresp come straight from flops; response is tied to okay
    assign o_hrdata                      = hrdata_ff;
    assign o_hreadyout                   = hreadyout_ff;
    assign o_hresp                       = spdc_pkg::HRESP_OKAY;
    assign o_conv_rsp                    = conv_rsp_ff;
    assign o_alt_routing_forward_enable  = enable_out_ff;
    assign o_alt_routing_forward_capable = capable_out_ff;

endmodule

`default_nettype wire

// *** switch_port_device_control2_bench.sv ***
// testbench: table-driven register and conversion checks for the control-two block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module switch_port_device_control2_bench;
    // ------------------------------------------------------------
    // stimulus rows: kind 0 write, 1 read, 2 conversion check
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  kind;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } spdc_row_t;
    spdc_row_t rows [21] = '{
        '{2'h1, 12'h068, 32'h0, 32'h0}, '{2'h1, 12'h064, 32'h0, 32'h420},
        '{2'h2, 12'h000, 32'h3, 32'hA3}, '{2'h2, 12'h000, 32'h0, 32'hE0},
        '{2'h0, 12'h068, 32'hFFFFFFFF, 32'h0}, '{2'h1, 12'h068, 32'h0, 32'h20},
        '{2'h2, 12'h000, 32'h3, 32'hC3}, '{2'h0, 12'h064, 32'h0, 32'h0},
        '{2'h1, 12'h068, 32'h0, 32'h0}, '{2'h1, 12'h064, 32'h0, 32'h400},
        '{2'h0, 12'h068, 32'h0, 32'h0},
        '{2'h0, 12'h064, 32'h20, 32'h0}, '{2'h1, 12'h068, 32'h0, 32'h20},
        '{2'h0, 12'h080, 32'h1, 32'h0}, '{2'h1, 12'h068, 32'h0, 32'h0},
        '{2'h1, 12'h064, 32'h0, 32'h400}, '{2'h0, 12'h068, 32'h0, 32'h0},
        '{2'h0, 12'h064, 32'h0, 32'h0}, '{2'h0, 12'h080, 32'h0, 32'h0},
        '{2'h1, 12'h064, 32'h0, 32'h420}, '{2'h1, 12'h0FC, 32'h0, 32'h0}};
    // design inputs, all defined from time zero
    logic                     i_clk    = 1'b0;
    logic                     i_rst_n  = 1'b0;
    logic                     i_hsel   = 1'b0;
    logic [11:0]              i_haddr  = 12'h000;
    logic [1:0]               i_htrans = 2'h0;
    logic                     i_hwrite = 1'b0;
    logic [31:0]              i_hwdata = 32'h0;
    spdc_pkg::spdc_conv_t     i_conv   = '0;
    wire logic [31:0]         o_hrdata;
    wire logic                o_hreadyout;
    wire logic                o_hresp;
    wire spdc_pkg::spdc_conv_rsp_t o_conv_rsp;
    wire logic                o_en;
    wire logic                o_cap;
    wire logic [7:0]          rsp8 = o_conv_rsp;
    logic [31:0]              q;
    logic [1:0]               st;
    int                       num_errors = 0;
    int                       num_checks = 0;

    spdc_port_dev_ctl u_spdc_port_dev_ctl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_conv(i_conv),
        .o_conv_rsp(o_conv_rsp), .o_alt_routing_forward_enable(o_en),
        .o_alt_routing_forward_capable(o_cap));

    // 25 MHz clock
    initial begin
        forever #20 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // tasks: entered just after a rising edge, leave just after one
    // ------------------------------------------------------------
    // sampling at the falling edge sees what the next rising edge takes, without races
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_hsel <= 1'b1; i_haddr <= a; i_htrans <= spdc_pkg::HTRANS_NONSEQ; i_hwrite <= w;
        do @(negedge i_clk); while (o_hreadyout !== 1'b1);
        @(posedge i_clk);
        i_hsel <= 1'b0; i_htrans <= 2'h0; i_hwdata <= d;
        do @(negedge i_clk); while (o_hreadyout !== 1'b1);
        q = o_hrdata;
        st = {o_en, o_cap};
        @(posedge i_clk);
    endtask
    task automatic conv(input logic [4:0] dev);
        i_conv <= '{1'b1, dev};
        @(posedge i_clk);
        i_conv <= '0;
        @(negedge i_clk);
        q = {24'h0, rsp8};
        @(posedge i_clk);
    endtask
    task automatic do_reset(input int n);
        i_rst_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        @(negedge i_clk);
        `CHK({o_en, o_cap}, 2'b01)
        @(posedge i_clk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        @(posedge i_clk);
        do_reset(16);
        foreach (rows[k]) begin
            if (rows[k].kind == 2'h2) conv(rows[k].wdata[4:0]);
            else ahb(rows[k].kind == 2'h0, rows[k].addr, rows[k].wdata);
            if (rows[k].kind != 2'h0)
                `CHK(q, rows[k].exp)
            if (rows[k].kind == 2'h1 && rows[k].addr == 12'h068)
                `CHK(st[1], rows[k].exp[5])
            if (rows[k].kind == 2'h1 && rows[k].addr == 12'h064)
                `CHK(st[0], rows[k].exp[5])
        end
        // the write made while upstream was dropped, so the stored enable is back
        ahb(1'b0, 12'h068, 32'h0);
        `CHK(q, 32'h20)
        // back-to-back checks with enable cleared
        ahb(1'b1, 12'h068, 32'h0);
        ahb(1'b0, 12'h068, 32'h0);
        `CHK(q, 32'h0)
        i_conv <= '{1'b1, 5'h01};
        @(posedge i_clk);
        i_conv <= '{1'b1, 5'h00};
        @(negedge i_clk);
        `CHK(rsp8, 8'hA1)
        @(posedge i_clk);
        i_conv <= '0;
        @(negedge i_clk);
        `CHK(rsp8, 8'hE0)
        @(posedge i_clk);
        // reset in mid-run drops a set enable
        ahb(1'b1, 12'h068, 32'h20);
        @(negedge i_clk);
        `CHK({o_en, o_cap}, 2'h3)
        @(posedge i_clk);
        do_reset(2);
        ahb(1'b0, 12'h068, 32'h0);
        `CHK(q, 32'h0)
        final_report();
    end

    // watchdog well beyond the roughly 80 cycles the tests need
    initial begin
        repeat (3000) @(posedge i_clk);
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
